// >>> rtl/pixint_params.svh
// constants and function list of the interrupt expander with external channels
//
// Function
// - up to 96 peripheral request inputs are funnelled into fewer cpu lines.
// - requests form groups of eight, each group driving one of twelve lines.
// - each request owns a software-writable vector entry in a dedicated ram.
// - on service the winning vector goes out to the cpu well within 8 cycles.
// - each request has its own enable and a disabled one never reaches a line.
// - hardware picks the lowest pending enabled request of the serviced group.
// - only 43 positions are wired; the rest are set only on a software trigger.
// - there are three external channels, the third one nmi-capable.
// - the third channel goes to cpu line thirteen or to the cpu nmi input.
// - each channel detects falling, rising or both edges per its polarity.
// - each channel has its own enable and a disabled one raises nothing.
// - each channel has a 16-bit up counter cleared on every valid edge.
// - each channel takes any port a pin as its source through a selector.
// - timer one may also drive line thirteen and timer two drives line 14.
`ifndef PIXINT_PARAMS_SVH
`define PIXINT_PARAMS_SVH

`define PX_ENA_BASE 12'h000
`define PX_FLG_BASE 12'h040
`define PX_XCTL_BASE 12'h080
`define PX_CFG_ADDR 12'h08c
`define PX_XCNT_BASE 12'h090
`define PX_ISTAT_ADDR 12'h0a0
`define PX_ICLR_ADDR 12'h0a4
`define PX_IEN_ADDR 12'h0a8
`define PX_VEC_BASE 12'h200
`define PX_VEC_SPAN 12'h180

`define PX_XCTL_EN_BIT 0
`define PX_XCTL_FALL_BIT 1
`define PX_XCTL_RISE_BIT 2
`define PX_XCTL_SEL_LSB 3
`define PX_CFG_NMI_BIT 0
`define PX_CFG_T1_BIT 1
`define PX_ST_VEC_BIT 3

`define PX_ENA_RST 8'h00
`define PX_XCTL_RST 8'h00
`define PX_CFG_RST 2'h0
`define PX_IEN_RST 4'h0
`define PX_VEC_FETCH_CYC 8
`define PX_EXT_ONE_POS 7'h03
`define PX_EXT_TWO_POS 7'h04
`define PX_WIRED_MASK 96'h0000_0000_0000_07ff_ffff_ffff

`endif

// >>> rtl/pixint_pkg.sv
// types of the interrupt expander
package pixint_pkg;
  typedef enum logic [0:0] {
    PIXINT_FETCH_IDLE,
    PIXINT_FETCH_READ
  } pixint_fetch_st_t;
endpackage

// >>> rtl/pixint_ram_if.sv
// connection between the expander and its vector ram
`timescale 1ns/1ps
`default_nettype none
interface pixint_ram_if #(
  parameter int AW = 7,
  parameter int DW = 32
);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic bus_re;
  logic [AW-1:0] bus_addr;
  logic [DW-1:0] bus_rdata;
  logic fetch_re;
  logic [AW-1:0] fetch_addr;
  logic [DW-1:0] fetch_rdata;
  modport ctl (output we, waddr, wdata, bus_re, bus_addr, fetch_re,
    fetch_addr, input bus_rdata, fetch_rdata);
  modport mem (input we, waddr, wdata, bus_re, bus_addr, fetch_re,
    fetch_addr, output bus_rdata, fetch_rdata);
endinterface
`default_nettype wire

// >>> rtl/pixint_top.sv
// interrupt expander with vector ram and three external edge channels
`timescale 1ns/1ps
`default_nettype none
`include "pixint_params.svh"
module pixint_top import pixint_pkg::*; #(
  parameter int NREQ = 96,
  parameter int NGRP = 12,
  parameter int NPIN = 32,
  parameter logic [95:0] WIRED_MASK = `PX_WIRED_MASK
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [NREQ-1:0] periph_irq_i,
  input wire logic [NPIN-1:0] gpio_a_i,
  input wire logic timer1_irq_i,
  input wire logic timer2_irq_i,
  input wire logic cpu_ack_i,
  input wire logic [3:0] cpu_ack_grp_i,
  output logic [NGRP-1:0] cpu_group_irq_lines_o,
  output logic cpu_irq_line_thirteen_o,
  output logic cpu_irq_line_fourteen_o,
  output logic cpu_nmi_o,
  output logic [31:0] vector_o,
  output logic vector_valid_o,
  output logic irq_o
);
  localparam int SELW = $clog2(NPIN);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  logic [11:0] wa;
  logic in_vec;
  logic [NREQ-1:0] ena_q;
  logic [NREQ-1:0] flag_q;
  logic [NREQ-1:0] act;
  logic [NREQ-1:0] set_v;
  logic [NREQ-1:0] clr_v;
  logic [2:0] ch_pulse;
  logic [2:0] ch_qual;
  logic [23:0] ch_ctl;
  logic [47:0] ch_cnt;
  logic [1:0] cfg_q;
  logic [3:0] stat_q;
  logic [3:0] ien_q;
  logic [3:0] ev;
  logic [31:0] rmux;
  logic [31:0] reg_rdata_q;
  logic rd_ram_q;
  logic [7:0] grp_pend;
  logic win_hit;
  logic [6:0] win_idx;
  logic fetch_hit_q;
  pixint_fetch_st_t fst_q;

  pixint_ram_if #(.AW(7), .DW(32)) ram_if ();

  pixint_vec_ram #(.DEPTH(NREQ)) u_ram (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ram(ram_if.mem)
  );

  assign wa = {addr_i[11:2], 2'b00};
  assign in_vec = (wa >= `PX_VEC_BASE) && (wa < `PX_VEC_BASE + `PX_VEC_SPAN);
  assign act = flag_q & ena_q;

  // ram ports: bus writes and reads, plus the vector fetch
  assign ram_if.we = wr_i && in_vec;
  assign ram_if.waddr = 7'((wa - `PX_VEC_BASE) >> 2);
  assign ram_if.wdata = wdata_i;
  assign ram_if.bus_re = rd_i && in_vec;
  assign ram_if.bus_addr = 7'((wa - `PX_VEC_BASE) >> 2);
  assign ram_if.fetch_re = cpu_ack_i && fst_q == PIXINT_FETCH_IDLE;
  assign ram_if.fetch_addr = win_idx;

  // winner of the acknowledged group: lowest enabled pending position
  always_comb begin
    grp_pend = 8'h00;
    win_hit = 1'b0;
    win_idx = 7'h00;
    if (cpu_ack_grp_i < 4'(NGRP)) begin
      grp_pend = act[{cpu_ack_grp_i, 3'h0} +: 8];
    end
    for (int k = 7; k >= 0; k--) begin
      if (grp_pend[k]) begin
        win_hit = 1'b1;
        win_idx = {cpu_ack_grp_i, 3'(k)};
      end
    end
  end

  // request flags: wired inputs, external channels, software force
  always_comb begin
    set_v = periph_irq_i & WIRED_MASK;
    set_v[`PX_EXT_ONE_POS] = set_v[`PX_EXT_ONE_POS] | ch_pulse[0];
    set_v[`PX_EXT_TWO_POS] = set_v[`PX_EXT_TWO_POS] | ch_pulse[1];
    clr_v = '0;
    if (ram_if.fetch_re && win_hit) begin
      clr_v[win_idx] = 1'b1;
    end
    for (int g = 0; g < NGRP; g++) begin
      if (wr_i && wa == `PX_FLG_BASE + 12'(4 * g)) begin
        set_v[g*8 +: 8] = set_v[g*8 +: 8] | wdata_i[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else if (ce_i) begin
      flag_q <= (flag_q & ~clr_v) | set_v;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ena_q <= '0;
    end else if (ce_i) begin
      for (int g = 0; g < NGRP; g++) begin
        if (wr_i && wa == `PX_ENA_BASE + 12'(4 * g)) begin
          ena_q[g*8 +: 8] <= wdata_i[7:0];
        end
      end
    end
  end

  // group lines and the two direct cpu lines
  genvar g;
  for (g = 0; g < NGRP; g++) begin : g_line
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        cpu_group_irq_lines_o[g] <= 1'b0;
      end else if (ce_i) begin
        cpu_group_irq_lines_o[g] <= |act[g*8 +: 8];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cpu_irq_line_thirteen_o <= 1'b0;
      cpu_irq_line_fourteen_o <= 1'b0;
      cpu_nmi_o <= 1'b0;
    end else if (ce_i) begin
      cpu_irq_line_thirteen_o <= (ch_pulse[2] && !cfg_q[`PX_CFG_NMI_BIT]) ||
        (timer1_irq_i && cfg_q[`PX_CFG_T1_BIT]);
      cpu_irq_line_fourteen_o <= timer2_irq_i;
      cpu_nmi_o <= ch_pulse[2] && cfg_q[`PX_CFG_NMI_BIT];
    end
  end

  // vector fetch: ack taken, ram read, vector out two cycles later
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fst_q <= PIXINT_FETCH_IDLE;
      fetch_hit_q <= 1'b0;
      vector_o <= 32'h0;
      vector_valid_o <= 1'b0;
    end else if (ce_i) begin
      vector_valid_o <= 1'b0;
      case (fst_q)
        PIXINT_FETCH_IDLE: begin
          if (cpu_ack_i) begin
            fst_q <= PIXINT_FETCH_READ;
            fetch_hit_q <= win_hit;
          end
        end
        PIXINT_FETCH_READ: begin
          vector_o <= fetch_hit_q ? ram_if.fetch_rdata : 32'h0;
          vector_valid_o <= 1'b1;
          fst_q <= PIXINT_FETCH_IDLE;
        end
        default: fst_q <= PIXINT_FETCH_IDLE;
      endcase
    end
  end

  // external channels: pin select, sync, edge detect, timestamp
  genvar c;
  for (c = 0; c < 3; c++) begin : g_ch
    logic [7:0] ctl_q;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic [15:0] cnt_q;
    logic pulse_q;
    logic rise;
    logic fall;
    logic [SELW-1:0] sel;

    assign sel = ctl_q[`PX_XCTL_SEL_LSB +: SELW];
    assign rise = s2_q && !s3_q;
    assign fall = !s2_q && s3_q;
    assign ch_qual[c] = (rise && ctl_q[`PX_XCTL_RISE_BIT]) ||
      (fall && ctl_q[`PX_XCTL_FALL_BIT]);
    assign ch_pulse[c] = pulse_q;
    assign ch_ctl[c*8 +: 8] = ctl_q;
    assign ch_cnt[c*16 +: 16] = cnt_q;

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        ctl_q <= `PX_XCTL_RST;
      end else if (ce_i && wr_i && wa == `PX_XCTL_BASE + 12'(4 * c)) begin
        ctl_q <= wdata_i[7:0];
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end else if (ce_i) begin
        s1_q <= gpio_a_i[sel];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        pulse_q <= 1'b0;
      end else if (ce_i) begin
        pulse_q <= ch_qual[c] && ctl_q[`PX_XCTL_EN_BIT];
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        cnt_q <= 16'h0000;
      end else if (ce_i) begin
        cnt_q <= ch_qual[c] ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  // configuration and interrupt status registers
  assign ev = {vector_valid_o, ch_pulse};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_q <= `PX_CFG_RST;
      ien_q <= `PX_IEN_RST;
    end else if (ce_i && wr_i) begin
      if (wa == `PX_CFG_ADDR) begin
        cfg_q <= wdata_i[1:0];
      end
      if (wa == `PX_IEN_ADDR) begin
        ien_q <= wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stat_q <= 4'h0;
    end else if (ce_i) begin
      stat_q <= (stat_q & ~((wr_i && wa == `PX_ICLR_ADDR) ? wdata_i[3:0] :
        4'h0)) | ev;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(stat_q & ien_q);
    end
  end

  // register read path
  always_comb begin
    rmux = 32'h0;
    for (int k = 0; k < NGRP; k++) begin
      if (wa == `PX_ENA_BASE + 12'(4 * k)) begin
        rmux = {24'h0, ena_q[k*8 +: 8]};
      end
      if (wa == `PX_FLG_BASE + 12'(4 * k)) begin
        rmux = {24'h0, flag_q[k*8 +: 8]};
      end
    end
    for (int k = 0; k < 3; k++) begin
      if (wa == `PX_XCTL_BASE + 12'(4 * k)) begin
        rmux = {24'h0, ch_ctl[k*8 +: 8]};
      end
      if (wa == `PX_XCNT_BASE + 12'(4 * k)) begin
        rmux = {16'h0, ch_cnt[k*16 +: 16]};
      end
    end
    if (wa == `PX_CFG_ADDR) begin
      rmux = {30'h0, cfg_q};
    end
    if (wa == `PX_ISTAT_ADDR) begin
      rmux = {28'h0, stat_q};
    end
    if (wa == `PX_IEN_ADDR) begin
      rmux = {28'h0, ien_q};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_q <= 32'h0;
      rd_ram_q <= 1'b0;
    end else if (ce_i) begin
      rd_ram_q <= rd_i && in_vec;
      if (rd_i) begin
        reg_rdata_q <= rmux;
      end
    end
  end

  assign rdata_o = rd_ram_q ? ram_if.bus_rdata : reg_rdata_q;

  // checks
  a_group_line_gate: assert property (
    ce_i |=> cpu_group_irq_lines_o[0] == |$past(act[7:0]))
    else $error("group line does not follow enabled flags");
  a_vector_latency: assert property (
    (ram_if.fetch_re && ce_i) ##1 ce_i |=> vector_valid_o)
    else $error("vector not delivered two cycles after ack");
  a_vector_bound: assert property (
    ram_if.fetch_re |-> ##[1:`PX_VEC_FETCH_CYC] vector_valid_o)
    else $error("vector fetch exceeds eight cycles");
  a_disabled_silent: assert property (
    (ce_i && ena_q[7:0] == 8'h00) |=> !cpu_group_irq_lines_o[0])
    else $error("disabled group raised its line");
  a_winner_cleared: assert property (
    (ce_i && ram_if.fetch_re && win_hit && !set_v[win_idx])
    |=> !flag_q[$past(win_idx)])
    else $error("serviced request flag not cleared");
  a_unwired_quiet: assert property (
    (!flag_q[95] && !(wr_i && wa == `PX_FLG_BASE + 12'h02c)) |=> !flag_q[95])
    else $error("unwired position set without software");
  a_nmi_route: assert property (
    (ce_i && ch_pulse[2]) |=> (cpu_nmi_o != cpu_irq_line_thirteen_o) ||
    $past(timer1_irq_i && cfg_q[`PX_CFG_T1_BIT]))
    else $error("third channel not routed to exactly one line");
  a_ext_enable: assert property (
    (ce_i && !g_ch[0].ctl_q[`PX_XCTL_EN_BIT]) |=> !ch_pulse[0])
    else $error("disabled channel produced a pulse");
  a_stamp_clear: assert property (
    (ce_i && ch_qual[1]) |=> ch_cnt[31:16] == 16'h0000)
    else $error("timestamp not cleared on valid edge");
  a_stamp_wrap: assert property (
    (ce_i && !ch_qual[0] && ch_cnt[15:0] == 16'hffff)
    |=> ch_cnt[15:0] == 16'h0000 && !ch_pulse[0])
    else $error("timestamp wrap wrong");
  a_single_pulse: assert property (
    (ce_i && ch_pulse[0]) ##1 ce_i |-> !ch_pulse[0])
    else $error("edge pulse longer than one cycle");

  c_vector_hit: cover property (
    ram_if.fetch_re && win_hit ##2 vector_valid_o);
  c_nmi_path: cover property (cpu_nmi_o);
  c_line13_timer: cover property (
    cpu_irq_line_thirteen_o && cfg_q[`PX_CFG_T1_BIT]);
  c_status_irq: cover property (irq_o);
endmodule
`default_nettype wire

// >>> rtl/pixint_vec_ram.sv
// vector ram with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module pixint_vec_ram #(
  parameter int DEPTH = 96
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  pixint_ram_if.mem ram
);
  logic [31:0] mem_q [DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (ce_i && ram.we) begin
      mem_q[ram.waddr] <= ram.wdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ram.bus_rdata <= 32'h0;
      ram.fetch_rdata <= 32'h0;
    end else if (ce_i) begin
      if (ram.bus_re) begin
        ram.bus_rdata <= mem_q[ram.bus_addr];
      end
      if (ram.fetch_re) begin
        ram.fetch_rdata <= mem_q[ram.fetch_addr];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/peripheral_interrupt_expander_xint_tb.sv
// self-checking bench of the interrupt expander
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_expander_xint_tb;
  typedef struct {int pos; logic [31:0] vec;} pixint_row_t;
  pixint_row_t rows [3] = '{'{0, 32'h0000_1100}, '{13, 32'h0000_2200},
    '{42, 32'h0000_3300}};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic [3:0] dly = 4'h0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic [95:0] periph = 96'h0;
  logic [31:0] gpio = 32'h0;
  logic [31:0] rd_v, rd_w, rdata_o, vector_o;
  logic [11:0] lines;
  logic l13, l14, nmi, vld, irq, ack;
  logic [3:0] agrp, lat;
  int err_total = 0;
  int n_checks = 0;
  int a, b, c;
  always #10 core_clk_i = ~core_clk_i;
  pixint_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .periph_irq_i(periph), .gpio_a_i(gpio),
    .timer1_irq_i(t1), .timer2_irq_i(t2), .cpu_ack_i(ack),
    .cpu_ack_grp_i(agrp), .cpu_group_irq_lines_o(lines),
    .cpu_irq_line_thirteen_o(l13), .cpu_irq_line_fourteen_o(l14),
    .cpu_nmi_o(nmi), .vector_o(vector_o), .vector_valid_o(vld),
    .irq_o(irq));
  pixint_cpu_model u_cpu (.clk_i(core_clk_i), .rst_i(rst_i), .go_i(go),
    .dly_i(dly), .lines_i(lines), .vld_i(vld), .ack_o(ack),
    .grp_o(agrp), .lat_o(lat));
  task results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [11:0] ad, output logic [31:0] d);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task cnt(output int x, y, z);
    x = 0;
    y = 0;
    z = 0;
    repeat (8) begin
      @(posedge core_clk_i);
      t1 <= 1'b0;
      t2 <= 1'b0;
      #1;
      x += int'(l13);
      y += int'(nmi);
      z += int'(l14);
    end
  endtask
  task svc(input logic [31:0] exp);
    logic hit;
    hit = 1'b0;
    @(posedge core_clk_i);
    go <= 1'b1;
    for (int k = 0; k < 60 && !hit; k++) begin
      @(posedge core_clk_i);
      #1 hit = (vld === 1'b1);
    end
    chk(hit, 1);
    chk(vector_o, exp);
    chk(lat <= 4'h8, 1);
    @(posedge core_clk_i);
    go <= 1'b0;
  endtask
  task pulse(input int p);
    @(posedge core_clk_i);
    periph[p] <= 1'b1;
    @(posedge core_clk_i);
    periph[p] <= 1'b0;
    tick(2);
  endtask
  initial begin
    #1800000;
    err_total++;
    results();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk({lines, l13, l14, nmi, vld, irq}, 0);
    chk(vector_o, 0);
    rd(12'h000, rd_v);
    chk(rd_v, 0);
    rd(12'h0fc, rd_v);
    chk(rd_v, 0);
    for (int i = 0; i < 3; i++) begin
      wr(12'h200 + 12'(4 * rows[i].pos), rows[i].vec);
      rd(12'h200 + 12'(4 * rows[i].pos), rd_v);
      chk(rd_v, rows[i].vec);
      wr(12'(4 * (rows[i].pos / 8)), 32'(1 << (rows[i].pos % 8)));
      dly <= 4'(4 * i);
      pulse(rows[i].pos);
      chk(lines, 32'(1 << (rows[i].pos / 8)));
      svc(rows[i].vec);
      wr(12'(4 * (rows[i].pos / 8)), 32'h0);
      tick(2);
      chk(lines, 0);
    end
    pulse(9);
    chk(lines, 0);
    wr(12'h018, 32'h4);
    pulse(50);
    chk(lines, 0);
    wr(12'h2c8, 32'h5050);
    wr(12'h058, 32'h4);
    tick(2);
    chk(lines, 32'h040);
    svc(32'h5050);
    wr(12'h000, 32'hff);
    wr(12'h204, 32'haa01);
    wr(12'h208, 32'haa02);
    wr(12'h040, 32'h06);
    svc(32'haa01);
    svc(32'haa02);
    wr(12'h000, 32'h0);
    wr(12'h08c, 32'h1);
    wr(12'h088, 32'h2d);
    @(posedge core_clk_i);
    gpio[5] <= 1'b1;
    cnt(a, b, c);
    chk(a * 16 + b, 1);
    rd(12'h098, rd_v);
    chk(rd_v < 32'd16, 1);
    // clock enable low for five edges: the counter must hold
    @(posedge core_clk_i);
    ce <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    ce <= 1'b1;
    rd(12'h098, rd_w);
    chk(rd_w - rd_v, 3);
    @(posedge core_clk_i);
    gpio[5] <= 1'b0;
    cnt(a, b, c);
    chk(a + b, 0);
    wr(12'h08c, 32'h0);
    @(posedge core_clk_i);
    gpio[5] <= 1'b1;
    cnt(a, b, c);
    chk(a * 16 + b, 16);
    wr(12'h088, 32'h2c);
    @(posedge core_clk_i);
    gpio[5] <= 1'b0;
    tick(4);
    @(posedge core_clk_i);
    gpio[5] <= 1'b1;
    cnt(a, b, c);
    chk(a + b, 0);
    rd(12'h098, rd_v);
    chk(rd_v < 32'd16, 1);
    wr(12'h080, 32'h3f);
    wr(12'h0a4, 32'hf);
    @(posedge core_clk_i);
    gpio[7] <= 1'b1;
    tick(6);
    rd(12'h040, rd_v);
    chk(rd_v & 32'h8, 32'h8);
    rd(12'h0a0, rd_v);
    chk(rd_v & 32'h1, 32'h1);
    wr(12'h0a8, 32'h1);
    tick(2);
    chk(irq, 1);
    wr(12'h0a4, 32'h1);
    tick(2);
    chk(irq, 0);
    @(posedge core_clk_i);
    gpio[7] <= 1'b0;
    tick(6);
    chk(irq, 1);
    wr(12'h0a8, 32'h0);
    tick(2);
    chk(irq, 0);
    wr(12'h084, 32'h4d);
    @(posedge core_clk_i);
    gpio[9] <= 1'b1;
    tick(6);
    rd(12'h040, rd_v);
    chk(rd_v & 32'h18, 32'h18);
    wr(12'h08c, 32'h2);
    @(posedge core_clk_i);
    t1 <= 1'b1;
    cnt(a, b, c);
    chk(a, 1);
    @(posedge core_clk_i);
    t2 <= 1'b1;
    cnt(a, b, c);
    chk(c, 1);
    // channel one pin stays quiet: its counter must pass all ones and wrap
    rd(12'h090, rd_v);
    tick(65536);
    rd(12'h090, rd_w);
    chk((rd_w - rd_v) & 32'hffff, 2);
    results();
  end
endmodule
`default_nettype wire

// >>> verification/pixint_cpu_model.sv
// cpu side model: acks the lowest active group line and times the answer
`timescale 1ns/1ps
`default_nettype none
module pixint_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [3:0] dly_i,
  input wire logic [11:0] lines_i,
  input wire logic vld_i,
  output logic ack_o,
  output logic [3:0] grp_o,
  output logic [3:0] lat_o
);
  logic busy_q;
  logic [3:0] wait_q;
  function automatic logic [3:0] first_grp(input logic [11:0] l);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (l[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      grp_o <= 4'h0;
      lat_o <= 4'h0;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      lat_o <= lat_o + 4'h1;
      if (vld_i) begin
        busy_q <= 1'b0;
      end
      if (!busy_q && go_i && |lines_i) begin
        if (wait_q < dly_i) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          ack_o <= 1'b1;
          grp_o <= first_grp(lines_i);
          busy_q <= 1'b1;
          lat_o <= 4'h0;
          wait_q <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire
